// ==== common/far_pkg.sv ====
/*
 package for the fault auto-restart supervisor: fault indices, start modes,
 state encoding, timing counts and the packed carriers used at the ports.
 assumes a single 10 MHz control clock.
*/
package far_pkg;

  localparam int          FAR_NUM_FAULTS    = 5;
  localparam int          FAR_F_UNDERVOLT   = 0;
  localparam int          FAR_F_OVERVOLT    = 1;
  localparam int          FAR_F_OVERCURR    = 2;
  localparam int          FAR_F_REFLOSS     = 3;
  localparam int          FAR_F_TEMP        = 4;

  localparam int          FAR_CLK_HZ        = 10_000_000;
  localparam int          FAR_TICK_US       = 1000;
  localparam int          FAR_TICK_CYCLES   = FAR_CLK_HZ / 1_000_000 * FAR_TICK_US;
  localparam int          FAR_CNT_W         = 8;
  localparam int          FAR_TRIAL_W       = 20;
  localparam logic [7:0]  FAR_TRIES_RST     = 8'h00;
  localparam logic [19:0] FAR_TRIAL_RST     = 20'h00000;

  typedef enum logic
  {
    FAR_START_RAMP   = 1'b0,
    FAR_START_FLYING = 1'b1
  } far_start_mode_t;

  typedef enum logic [1:0]
  {
    FAR_ST_RUN     = 2'b00,
    FAR_ST_WAIT    = 2'b01,
    FAR_ST_LOCKOUT = 2'b10
  } far_state_t;

  typedef struct packed
  {
    logic [FAR_NUM_FAULTS-1:0] trip;
    logic [FAR_NUM_FAULTS-1:0] normal;
  } far_fault_t;

  typedef struct packed
  {
    logic [FAR_NUM_FAULTS-1:0] enable;
    logic [FAR_CNT_W-1:0]      max_tries;
    logic [FAR_TRIAL_W-1:0]    trial_ms;
    far_start_mode_t           start_mode;
  } far_cfg_t;

  typedef struct packed
  {
    logic            restart;
    far_start_mode_t mode;
  } far_cmd_t;

endpackage

// ==== logic/far_supervisor.sv ====
/*
 fault auto-restart supervisor: watches trip events and return-to-normal levels,
 issues restart pulses, limits restarts per trial window.
 a restart comes once every latched fault has been normal for NORMAL_HOLD + 1 cycles;
 the trial window opens at a restart and runs cfg.trial_ms milliseconds.
 limitation: a max_tries of zero never restarts, every qualifying fault locks out.
 assumes all inputs come from logic on the same clock; faults latch internally
 until a restart or a manual reset, which clear_lockout stands for here.
 assumes the enables and the start mode are held steady while a fault is pending.
*/
// Overview of operation
// - restart only after trips whose fault type has its restart enable set
// - at most the configured number of restarts within one trial window
// - trial window starts timing at the first restart, not at the fault
// - restart count cleared when the trial window elapses within the limit
// - after clearing, the next qualifying fault begins a fresh sequence and window
// - start mode 0 ramps, mode 1 uses flying start
// - undervoltage restart waits for bus voltage back at normal level
// - overvoltage restart waits for bus voltage back at normal level
// - overcurrent restart only when its enable is 1
// - reference-loss restart waits for current reference at or above minimum
// - temperature restart waits for heatsink temperature inside its window
module far_supervisor
  import far_pkg::*;
#(
  parameter int NORMAL_HOLD = 16
)
(
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  input  wire far_pkg::far_fault_t              faults,
  input  wire far_pkg::far_cfg_t                cfg,
  input  wire logic                             clear_lockout,
  output far_pkg::far_cmd_t                     cmd,
  output logic                                  faulted,
  output logic                                  lockout,
  output logic [far_pkg::FAR_CNT_W-1:0]         restart_count,
  output logic                                  window_open
);

  import far_pkg::*;

  localparam int HOLD_W = $clog2(NORMAL_HOLD + 1);
  localparam int TICK_W = $clog2(FAR_TICK_CYCLES + 1);

  typedef struct packed
  {
    far_state_t                state;
    logic [FAR_NUM_FAULTS-1:0] pending;
    logic [HOLD_W-1:0]         hold;
    logic [FAR_CNT_W-1:0]      count;
    logic                      win;
    logic [FAR_TRIAL_W-1:0]    win_ms;
    logic [TICK_W-1:0]         tick;
    far_cmd_t                  cmd;
  } far_regs_t;

  // one value for power-up and for leaving lockout, so both start from the same place
  localparam far_regs_t REGS_RESET = '{
    state:   FAR_ST_RUN,
    pending: '0,
    hold:    '0,
    count:   FAR_TRIES_RST,
    win:     1'b0,
    win_ms:  FAR_TRIAL_RST,
    tick:    '0,
    cmd:     '{restart: 1'b0, mode: FAR_START_RAMP}
  };

  far_regs_t st_reg;
  far_regs_t st_next;

  logic [FAR_NUM_FAULTS-1:0] fault_seen;
  logic [FAR_NUM_FAULTS-1:0] fault_ready;
  logic [FAR_NUM_FAULTS-1:0] fault_refused;
  logic [FAR_NUM_FAULTS-1:0] fault_allowed;
  logic                      trip_now;
  logic                      all_normal;
  logic                      any_refused;
  logic                      any_allowed;
  logic                      limit_used;
  logic                      hold_done;
  logic                      ms_tick;
  logic                      win_done;

  // one slice per fault type: latched, back to normal, refused, allowed to restart
  for (genvar f = 0; f < FAR_NUM_FAULTS; f++)
  begin : g_fault
    assign fault_seen[f]    = st_reg.pending[f] | faults.trip[f];
    // a fault that never latched does not hold back a restart
    assign fault_ready[f]   = faults.normal[f] | ~fault_seen[f];
    assign fault_refused[f] = fault_seen[f] & ~cfg.enable[f];
    assign fault_allowed[f] = fault_seen[f] & cfg.enable[f];
  end

  always_comb
  begin
    trip_now    = |faults.trip;
    all_normal  = &fault_ready;
    any_refused = |fault_refused;
    any_allowed = |fault_allowed;
    hold_done   = (st_reg.hold >= HOLD_W'(NORMAL_HOLD));
    ms_tick     = (st_reg.tick == TICK_W'(FAR_TICK_CYCLES - 1));
    win_done    = st_reg.win && ms_tick && (st_reg.win_ms + 20'h00001 >= cfg.trial_ms);
    // a window that ends this cycle frees the limit at once
    if (win_done)
      limit_used = (cfg.max_tries == '0);
    else
      limit_used = (st_reg.count >= cfg.max_tries);

    st_next             = st_reg;
    st_next.cmd.restart = 1'b0;
    st_next.pending     = fault_seen;

    // millisecond prescaler and window counter only run while a window is open
    if (st_reg.win)
    begin
      if (ms_tick)
      begin
        st_next.tick   = '0;
        st_next.win_ms = st_reg.win_ms + 20'h00001;
      end
      else
      begin
        st_next.tick = st_reg.tick + TICK_W'(1);
      end
    end
    if (win_done)
    begin
      // limit was held over the whole window
      st_next.win    = 1'b0;
      st_next.count  = FAR_TRIES_RST;
      st_next.win_ms = FAR_TRIAL_RST;
      st_next.tick   = '0;
    end

    case (st_reg.state)
      FAR_ST_RUN:
      begin
        if (trip_now)
        begin
          st_next.state = FAR_ST_WAIT;
        end
        st_next.hold = '0;
      end
      FAR_ST_WAIT:
      begin
        if (any_refused)
        begin
          st_next.state = FAR_ST_LOCKOUT;
        end
        else if (limit_used)
        begin
          // no restart left in this window: stay faulted
          st_next.state = FAR_ST_LOCKOUT;
        end
        else if (!all_normal || trip_now)
        begin
          st_next.hold = '0;
        end
        else if (!hold_done)
        begin
          st_next.hold = st_reg.hold + HOLD_W'(1);
        end
        else if (any_allowed)
        begin
          st_next.cmd.restart = 1'b1;
          st_next.cmd.mode    = cfg.start_mode;
          st_next.count       = st_next.count + FAR_CNT_W'(1);
          st_next.pending     = '0;
          st_next.hold        = '0;
          st_next.state       = FAR_ST_RUN;
          // the window opens at a restart, never at the fault
          if (!st_reg.win || win_done)
          begin
            st_next.win    = 1'b1;
            st_next.win_ms = FAR_TRIAL_RST;
            st_next.tick   = '0;
          end
        end
      end
      FAR_ST_LOCKOUT:
      begin
        // stays faulted until an outside reset
        if (clear_lockout)
        begin
          st_next         = REGS_RESET;
          // a trip in the clearing cycle is kept, not lost
          st_next.pending = faults.trip;
          if (trip_now)
          begin
            st_next.state = FAR_ST_WAIT;
          end
        end
      end
      default:
      begin
        st_next.state = FAR_ST_LOCKOUT;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg <= REGS_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // every output comes straight from the state register
  assign cmd           = st_reg.cmd;
  assign faulted       = (st_reg.state != FAR_ST_RUN);
  assign lockout       = (st_reg.state == FAR_ST_LOCKOUT);
  assign restart_count = st_reg.count;
  assign window_open   = st_reg.win;

endmodule

// ==== tb/far_drive_model.sv ====
/*
 drive-side fault source: one-cycle trip, then the fault's normal level held low
 for dly cycles. assumes the bench clock and far_pkg.
*/
module far_drive_model
  import far_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [2:0] idx,
  input  wire logic [4:0] dly,
  output far_pkg::far_fault_t faults
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt = 5'h00;
  initial faults = '{trip: 5'h00, normal: 5'h1f};
  always @(negedge clk)
  begin
    faults.trip <= fire ? 5'h01 << idx : 5'h00;
    // condition stays abnormal a while after the trip
    faults.normal <= fire ? ~(5'h01 << idx) : (cnt == 5'h00 ? 5'h1f : faults.normal);
    cnt <= fire ? dly : cnt - {4'h0, cnt != 5'h00};
  end
endmodule

// ==== tb/far_supervisor_chk.sv ====
/*
 assertions on the supervisor ports. assumes the bound module's parameter.
*/
module far_supervisor_chk
  import far_pkg::*;
#(parameter int NORMAL_HOLD = 16)
(
  input wire logic                           clk,
  input wire logic                           sys_rst,
  input wire far_pkg::far_fault_t            faults,
  input wire far_pkg::far_cfg_t              cfg,
  input wire logic                           clear_lockout,
  input wire far_pkg::far_cmd_t              cmd,
  input wire logic                           faulted,
  input wire logic                           lockout,
  input wire logic [far_pkg::FAR_CNT_W-1:0]  restart_count,
  input wire logic                           window_open
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_enable_only: assert property ((|(faults.trip & ~cfg.enable)) && !lockout |-> ##[1:20] lockout)
    else $error("disabled fault did not lock out");
  chk_count_limit: assert property (cmd.restart |-> restart_count <= cfg.max_tries)
    else $error("restart beyond limit");
  chk_count_step: assert property (cmd.restart |-> restart_count == $past(restart_count) + 8'h01
    || restart_count == 8'h01)
    else $error("count step wrong");
  chk_window_start: assert property ($rose(window_open) |-> cmd.restart)
    else $error("window opened without restart");
  chk_count_clear: assert property ($fell(window_open) && !cmd.restart |-> restart_count == 8'h00)
    else $error("count kept after window");
  chk_mode_latch: assert property (cmd.restart |-> cmd.mode == $past(cfg.start_mode))
    else $error("start mode wrong");
  chk_lock_quiet: assert property (lockout |-> !cmd.restart)
    else $error("restart in lockout");
  chk_trip_hold: assert property ((|faults.trip) && !lockout |=> !cmd.restart [*3])
    else $error("restart during hold");
  chk_no_trip: assert property (cmd.restart |-> $past(faults.trip) == 5'h00 && $past(faults.trip, 2) == 5'h00)
    else $error("restart right after a trip");
endmodule
bind far_supervisor far_supervisor_chk #(.NORMAL_HOLD(NORMAL_HOLD)) chk (.*);

// ==== tb/test_far_supervisor.sv ====
/*
 self-checking bench: each fault type restarts, the window clears the count,
 the limit and a disabled fault lock out. assumes NORMAL_HOLD 2, 1 ms window.
*/
module test_far_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  import far_pkg::*;
  localparam int HOLD = 2;
  logic clk = 1'b0, sys_rst = 1'b1, fire = 1'b0, clear_lockout = 1'b0, faulted, lockout, window_open, got;
  logic [2:0] idx = 3'h0;
  logic [4:0] dly = 5'h00;
  logic [7:0] restart_count;
  logic [7:0] lat;
  int waited;
  far_fault_t faults;
  far_cmd_t cmd;
  far_cfg_t cfg = '{enable: 5'h1f, max_tries: 8'h02, trial_ms: 20'h00001, start_mode: FAR_START_RAMP};
  int mismatches = 0, checks_done = 0;
  far_drive_model drv (.clk(clk), .fire(fire), .idx(idx), .dly(dly), .faults(faults));
  far_supervisor #(.NORMAL_HOLD(HOLD)) dut (.clk(clk), .sys_rst(sys_rst), .faults(faults), .cfg(cfg),
    .clear_lockout(clear_lockout), .cmd(cmd), .faulted(faulted), .lockout(lockout),
    .restart_count(restart_count), .window_open(window_open));
  initial forever #50 clk = ~clk;
  task check(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task run(logic [2:0] i, logic [4:0] d, logic e, logic [7:0] c);
    @(negedge clk);
    // non-blocking, so the drive model reads the request at the next falling edge
    fire <= 1'b1;
    idx  <= i;
    dly  <= d;
    @(negedge clk);
    fire <= 1'b0;
    got = 1'b0;
    lat = 8'h00;
    for (int j = 1; j <= 60; j++)
    begin
      @(negedge clk);
      if (cmd.restart === 1'b1 && got === 1'b0) lat = 8'(j);
      if (cmd.restart === 1'b1) got = 1'b1;
    end
    check("restart", {7'h0, e}, {7'h0, got});
    check("latency", e ? {3'h0, d} + 8'(HOLD + 2) : 8'h00, lat);
    check("count", c, restart_count);
    check("lockout", {7'h0, !e}, {7'h0, lockout});
    check("faulted", {7'h0, !e}, {7'h0, faulted});
  endtask
  task unlock;
    clear_lockout = 1'b1;
    @(negedge clk);
    clear_lockout = 1'b0;
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    for (int f = 0; f < 5; f++)
    begin
      cfg.start_mode = far_start_mode_t'(f[0]);
      run(f[2:0], f[0] ? 5'h14 : 5'h00, 1'b1, 8'h01);
      check("mode", {7'h0, f[0]}, {7'h0, cmd.mode});
      for (waited = 0; waited < 10100 && window_open === 1'b1; waited++) @(negedge clk);
      // one ms window counted from the restart seen lat cycles into the 60-cycle run loop
      check("window", 8'h01, {7'h0, waited == FAR_TICK_CYCLES - 60 + int'(lat)});
      check("cleared", 8'h00, restart_count);
    end
    run(3'h2, 5'h03, 1'b1, 8'h01);
    run(3'h2, 5'h03, 1'b1, 8'h02);
    run(3'h2, 5'h03, 1'b0, 8'h02);
    unlock();
    check("unlocked", 8'h00, {7'h0, lockout});
    cfg.enable = 5'h1b;
    run(3'h2, 5'h00, 1'b0, 8'h00);
    unlock();
    stop_test();
  end
  initial
  begin
    repeat (80000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule
